// ==== rtl/adcraf_pkg.sv ====
// Package of constants and types for the converter accumulate and format stage
//==========================================================================
// Summary of operation
// RL1 - Repeat field 00/01/10/11 selects 1, 4, 8 or 16 summed conversions.
// RL2 - Done and window flags are raised once per completed repeat set only.
// RL3 - Burst off: every conversion of the set needs its own start trigger.
// RL4 - Burst on: one trigger runs the whole set back to back, self-timed.
// RL5 - Each conversion result is added into the high/low result byte pair.
// RL6 - Software keeps left justify at zero when repeat field is not 00.
// RL7 - Right justified, repeat 00: high byte bits 3-0 upper result bits.
// RL8 - Right justified, repeat 01: high byte bits 4-0 upper sum bits.
// RL9 - Right justified, repeat 10: high byte bits 5-0 upper sum bits.
// RL10 - Right justified, repeat 11: high byte holds upper 8 sum bits.
// RL11 - Left justified: high byte holds eight MSBs of the 12-bit result.
// RL12 - Right justified: low byte holds low eight bits of the accumulated sum.
// RL13 - Left justified: low byte bits 7-4 hold result bits 3-0, rest zero.
// RL14 - Configuration bit 0 enables the gain programming path.
// RL15 - Software rounds the clock divider quotient up, never truncates.
// RL16 - Conversion clock divides source by five-bit divider field plus one.
// RL17 - Divider source is system clock, or internal clock when bursting. Code instead divides the system clock by fixed BURST_DIV plus one when bursting.
// RL18 - Done flag reads one after a completed repeat set since last clear.
// RL19 - Writing one to busy starts conversion only when start source is 00.
// RL20 - Accumulator clears at the first conversion of each new repeat set.
// RL21 - High and low result bytes update together at the end of a set.
`default_nettype none
package adcraf_pkg;
  localparam int RES_W = 12;
  localparam int ACC_W = 16;
  localparam logic [7:0] ADDR_LOW = 8'hBD;
  localparam logic [7:0] ADDR_HIGH = 8'hBE;
  localparam logic [7:0] ADDR_CFG = 8'hBC;
  localparam logic [7:0] ADDR_CTL = 8'hE8;
  localparam logic [7:0] CFG_RESET = 8'hF8;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam int CFG_GAIN_BIT = 0;
  localparam int CFG_RPT_LSB = 1;
  localparam int CFG_DIV_LSB = 3;
  localparam int CTL_CM_LSB = 0;
  localparam int CTL_LJ_BIT = 2;
  localparam int CTL_WIN_BIT = 3;
  localparam int CTL_BUSY_BIT = 4;
  localparam int CTL_DONE_BIT = 5;
  localparam int CTL_BURST_BIT = 6;
  localparam int CTL_EN_BIT = 7;
  localparam logic [1:0] CM_SOFTWARE = 2'h0;
  // Conversion time in SAR clocks, less one: track plus 12 bit decisions plus one
  localparam logic [4:0] SAR_CLOCKS = 5'h0E;
  localparam logic [4:0] BURST_DIV = 5'h01;
  typedef struct packed {
    logic [4:0] divider;
    logic [1:0] repeat_count_field;
    logic gain_program_on;
  } adcraf_cfg_s;
  typedef struct packed {
    logic enable;
    logic burst_run_on;
    logic left_justify_sel;
    logic [1:0] start_source_sel;
  } adcraf_ctl_s;
endpackage
`default_nettype wire

// ==== rtl/adcraf_sar_core.sv ====
// Timed conversion engine: divided SAR clock and a result capture per start
`default_nettype none
module adcraf_sar_core #(
  parameter int DIV_W = 5
) (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic start_i,
  input wire logic [DIV_W-1:0] divider_i,
  input wire logic [adcraf_pkg::RES_W-1:0] sample_i,
  output logic busy_o,
  output logic done_o,
  output logic [adcraf_pkg::RES_W-1:0] result_o
);
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic busy, next_busy;
  logic done, next_done;
  logic [adcraf_pkg::RES_W-1:0] result, next_result;

  always_comb begin
    next_div_cnt = div_cnt;
    next_bit_cnt = bit_cnt;
    next_busy = busy;
    next_done = 1'b0;
    next_result = result;
    if (!busy) begin
      if (start_i) begin
        next_busy = 1'b1;
        next_div_cnt = divider_i;
        next_bit_cnt = adcraf_pkg::SAR_CLOCKS;
      end
    end else if (div_cnt != '0) begin
      next_div_cnt = div_cnt - 1'b1;
    end else begin
      // One SAR clock is divider plus one system clocks
      next_div_cnt = divider_i; // RL16
      if (bit_cnt == 5'h00) begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_result = sample_i;
      end else begin
        next_bit_cnt = bit_cnt - 5'h01;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      div_cnt <= '0;
      bit_cnt <= 5'h00;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end else begin
      div_cnt <= next_div_cnt;
      bit_cnt <= next_bit_cnt;
      busy <= next_busy;
      done <= next_done;
      result <= next_result;
    end
  end

  assign busy_o = busy;
  assign done_o = done;
  assign result_o = result;
endmodule
`default_nettype wire

// ==== rtl/adcraf_top.sv ====
// Accumulate and format stage of the converter, reached through its SFRs
`default_nettype none
module adcraf_top (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  output logic [7:0] SFR_RDATA_O,
  input wire logic EXT_START_I,
  input wire logic [adcraf_pkg::RES_W-1:0] SAMPLE_I,
  input wire logic WINDOW_HIT_I,
  output logic GAIN_PATH_ON_O,
  output logic CONVERSION_DONE_O
);
  //==========================================================================
  // Registers
  adcraf_pkg::adcraf_cfg_s cfg, next_cfg;
  adcraf_pkg::adcraf_ctl_s ctl, next_ctl;
  logic conversion_done_flag, next_conversion_done_flag;
  logic window_match_flag, next_window_match_flag;
  logic [7:0] result_high_byte, next_result_high_byte;
  logic [7:0] result_low_byte, next_result_low_byte;
  logic [adcraf_pkg::ACC_W-1:0] acc, next_acc;
  logic [3:0] conv_cnt, next_conv_cnt;
  logic burst_pending, next_burst_pending;
  logic [7:0] rdata, next_rdata;
  logic ext_meta, ext_sync, ext_prev;
  logic win_meta, win_sync;

  logic core_start, core_busy, core_done;
  logic [adcraf_pkg::RES_W-1:0] core_result;
  logic [4:0] core_div;
  logic wr_ctl, trigger, set_end;
  logic sw_start, ext_start;
  logic [3:0] last_index;
  logic [adcraf_pkg::ACC_W-1:0] sum;
  logic [7:0] fmt_high, fmt_low;

  //==========================================================================
  // Start decode
  assign wr_ctl = SFR_WR_I && (SFR_ADDR_I == adcraf_pkg::ADDR_CTL);

  // Software start decodes the bits being written, so one write can enable and start
  always_comb begin
    sw_start = wr_ctl && SFR_WDATA_I[adcraf_pkg::CTL_BUSY_BIT]
      && SFR_WDATA_I[adcraf_pkg::CTL_EN_BIT]
      && SFR_WDATA_I[adcraf_pkg::CTL_CM_LSB +: 2] == adcraf_pkg::CM_SOFTWARE; // RL19
    // External edges only count once the stored source selects them
    ext_start = ext_sync && !ext_prev && ctl.enable
      && ctl.start_source_sel != adcraf_pkg::CM_SOFTWARE;
    trigger = sw_start || ext_start;
  end

  // Index of the last conversion in a set
  always_comb begin
    case (cfg.repeat_count_field) // RL1
      2'h0: last_index = 4'h0;
      2'h1: last_index = 4'h3;
      2'h2: last_index = 4'h7;
      default: last_index = 4'hF;
    endcase
  end

  // Burst keeps issuing starts itself; otherwise each conversion needs a trigger
  assign core_start = !core_busy && (trigger || burst_pending); // RL3 RL4
  // Burst runs from a fixed fast divider standing in for the internal clock
  assign core_div = ctl.burst_run_on ? adcraf_pkg::BURST_DIV : cfg.divider; // RL17

  adcraf_sar_core #(
    .DIV_W(5)
  ) i_adcraf_sar_core (
    .MCLK_I(MCLK_I),
    .SRST_I(SRST_I),
    .start_i(core_start),
    .divider_i(core_div),
    .sample_i(SAMPLE_I),
    .busy_o(core_busy),
    .done_o(core_done),
    .result_o(core_result)
  );

  //==========================================================================
  // Accumulation and formatting
  always_comb begin
    if (conv_cnt == 4'h0) begin
      sum = {4'h0, core_result}; // RL20
    end else begin
      sum = acc + {4'h0, core_result}; // RL5
    end
  end
  assign set_end = core_done && (conv_cnt == last_index); // RL2

  always_comb begin
    fmt_low = sum[7:0]; // RL12
    case (cfg.repeat_count_field)
      2'h0: fmt_high = {4'h0, sum[11:8]}; // RL7
      2'h1: fmt_high = {3'h0, sum[12:8]}; // RL8
      2'h2: fmt_high = {2'h0, sum[13:8]}; // RL9
      default: fmt_high = sum[15:8]; // RL10
    endcase
    if (ctl.left_justify_sel) begin
      fmt_high = core_result[11:4]; // RL11
      fmt_low = {core_result[3:0], 4'h0}; // RL13
    end
  end

  always_comb begin
    next_acc = acc;
    next_conv_cnt = conv_cnt;
    next_burst_pending = burst_pending;
    next_result_high_byte = result_high_byte;
    next_result_low_byte = result_low_byte;
    if (core_start) begin
      next_burst_pending = 1'b0;
    end
    // A set end overrides a software write to the result bytes in the same cycle
    if (core_done) begin
      next_acc = sum;
      if (set_end) begin
        next_conv_cnt = 4'h0;
        next_result_high_byte = fmt_high; // RL21
        next_result_low_byte = fmt_low; // RL21
      end else begin
        next_conv_cnt = conv_cnt + 4'h1;
        next_burst_pending = ctl.burst_run_on; // RL4
      end
    end else if (SFR_WR_I && SFR_ADDR_I == adcraf_pkg::ADDR_HIGH) begin
      next_result_high_byte = SFR_WDATA_I;
    end else if (SFR_WR_I && SFR_ADDR_I == adcraf_pkg::ADDR_LOW) begin
      next_result_low_byte = SFR_WDATA_I;
    end
    // Disabling abandons a partly counted set
    if (!ctl.enable) begin
      next_conv_cnt = 4'h0;
      next_burst_pending = 1'b0;
    end
  end

  //==========================================================================
  // Flags and configuration
  always_comb begin
    next_cfg = cfg;
    next_ctl = ctl;
    next_conversion_done_flag = conversion_done_flag;
    next_window_match_flag = window_match_flag;
    if (SFR_WR_I && SFR_ADDR_I == adcraf_pkg::ADDR_CFG) begin
      next_cfg = SFR_WDATA_I;
    end
    if (wr_ctl) begin
      next_ctl.enable = SFR_WDATA_I[adcraf_pkg::CTL_EN_BIT];
      next_ctl.burst_run_on = SFR_WDATA_I[adcraf_pkg::CTL_BURST_BIT];
      next_ctl.left_justify_sel = SFR_WDATA_I[adcraf_pkg::CTL_LJ_BIT];
      next_ctl.start_source_sel = SFR_WDATA_I[adcraf_pkg::CTL_CM_LSB +: 2];
      next_conversion_done_flag = SFR_WDATA_I[adcraf_pkg::CTL_DONE_BIT];
      next_window_match_flag = SFR_WDATA_I[adcraf_pkg::CTL_WIN_BIT];
    end
    // Hardware set wins over a software clear in the same cycle
    if (set_end) begin
      next_conversion_done_flag = 1'b1; // RL18
      if (win_sync) begin
        next_window_match_flag = 1'b1; // RL2
      end
    end
  end

  always_comb begin
    case (SFR_ADDR_I)
      adcraf_pkg::ADDR_LOW: next_rdata = result_low_byte;
      adcraf_pkg::ADDR_HIGH: next_rdata = result_high_byte;
      adcraf_pkg::ADDR_CFG: next_rdata = cfg;
      adcraf_pkg::ADDR_CTL: next_rdata = {ctl.enable, ctl.burst_run_on,
        conversion_done_flag, core_busy || burst_pending, window_match_flag,
        ctl.left_justify_sel, ctl.start_source_sel};
      default: next_rdata = 8'h00;
    endcase
    if (!SFR_RD_I) begin
      next_rdata = rdata;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      cfg <= adcraf_pkg::CFG_RESET;
      ctl <= '0;
      conversion_done_flag <= 1'b0;
      window_match_flag <= 1'b0;
      result_high_byte <= 8'h00;
      result_low_byte <= 8'h00;
      acc <= '0;
      conv_cnt <= 4'h0;
      burst_pending <= 1'b0;
      rdata <= 8'h00;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
      win_meta <= 1'b0;
      win_sync <= 1'b0;
    end else begin
      cfg <= next_cfg;
      ctl <= next_ctl;
      conversion_done_flag <= next_conversion_done_flag;
      window_match_flag <= next_window_match_flag;
      result_high_byte <= next_result_high_byte;
      result_low_byte <= next_result_low_byte;
      acc <= next_acc;
      conv_cnt <= next_conv_cnt;
      burst_pending <= next_burst_pending;
      rdata <= next_rdata;
      ext_meta <= EXT_START_I;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
      win_meta <= WINDOW_HIT_I;
      win_sync <= win_meta;
    end
  end

  assign SFR_RDATA_O = rdata;
  assign GAIN_PATH_ON_O = cfg.gain_program_on; // RL14
  assign CONVERSION_DONE_O = conversion_done_flag;
endmodule
`default_nettype wire

// ==== testbench/adcraf_top_chk.sv ====
// Port checker of the accumulate and format stage
`default_nettype none
module adcraf_top_chk (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic EXT_START_I,
  input wire logic [adcraf_pkg::RES_W-1:0] SAMPLE_I,
  input wire logic WINDOW_HIT_I,
  input wire logic GAIN_PATH_ON_O,
  input wire logic CONVERSION_DONE_O
);
  logic cfg_wr;
  logic next_cfg_wr;
  logic cfg_sel;
  logic ctl_wr;
  assign cfg_sel = SFR_ADDR_I == adcraf_pkg::ADDR_CFG;
  assign ctl_wr = SFR_WR_I && SFR_ADDR_I == adcraf_pkg::ADDR_CTL;
  always_comb begin
    next_cfg_wr = cfg_wr | (SFR_WR_I & cfg_sel);
  end
  always_ff @(posedge MCLK_I) begin
    cfg_wr <= SRST_I ? 1'b0 : next_cfg_wr;
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  sequence s_start;
    ctl_wr && SFR_WDATA_I[7] && SFR_WDATA_I[4] && SFR_WDATA_I[1:0] == 2'h0 && !SFR_WDATA_I[5];
  endsequence
  sequence s_gain_wr(b);
    SFR_WR_I && cfg_sel && SFR_WDATA_I[0] == b;
  endsequence
  property p_rst;
    disable iff (1'b0) SRST_I |=> !CONVERSION_DONE_O && !GAIN_PATH_ON_O && SFR_RDATA_O == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_cfg_reset;
    SFR_RD_I && cfg_sel && !cfg_wr |=> SFR_RDATA_O == adcraf_pkg::CFG_RESET;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong");
  property p_unmapped;
    SFR_RD_I && !(SFR_ADDR_I inside {8'hBC, 8'hBD, 8'hBE, 8'hE8}) |=> SFR_RDATA_O == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold;
    !SFR_RD_I |=> $stable(SFR_RDATA_O);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_done_fall;
    $fell(CONVERSION_DONE_O) |-> $past(ctl_wr, 1) || $past(ctl_wr, 2);
  endproperty
  a_done_fall: assert property (p_done_fall) else $error("done fell uncleared");
  property p_min_time;
    s_start |-> ##3 !CONVERSION_DONE_O [*8];
  endproperty
  a_min_time: assert property (p_min_time) else $error("done too soon after start");
  property p_gain_on;
    s_gain_wr(1'b1) |-> ##[1:2] GAIN_PATH_ON_O;
  endproperty
  a_gain_on: assert property (p_gain_on) else $error("gain path not on");
  property p_gain_off;
    s_gain_wr(1'b0) |-> ##[1:2] !GAIN_PATH_ON_O;
  endproperty
  a_gain_off: assert property (p_gain_off) else $error("gain path not off");
endmodule
bind adcraf_top adcraf_top_chk i_adcraf_top_chk (.MCLK_I(MCLK_I), .SRST_I(SRST_I),
  .SFR_ADDR_I(SFR_ADDR_I), .SFR_WDATA_I(SFR_WDATA_I), .SFR_WR_I(SFR_WR_I),
  .SFR_RD_I(SFR_RD_I), .SFR_RDATA_O(SFR_RDATA_O), .EXT_START_I(EXT_START_I),
  .SAMPLE_I(SAMPLE_I), .WINDOW_HIT_I(WINDOW_HIT_I), .GAIN_PATH_ON_O(GAIN_PATH_ON_O),
  .CONVERSION_DONE_O(CONVERSION_DONE_O));
`default_nettype wire

// ==== testbench/adcraf_top_tb.sv ====
// Self-checking bench of the accumulate and format stage
`default_nettype none
module adcraf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext = 1'b0;
  logic [11:0] smp = 12'hABC;
  logic win = 1'b0;
  logic [7:0] rdat;
  logic gain;
  logic done;
  int n_fail = 0;
  int cmp_count = 0;
  // Divider rounded up so the SAR clock never exceeds its target
  localparam int sys_mhz = 50;
  localparam int sar_mhz = 50;
  localparam int sar_div = (sys_mhz + sar_mhz - 1) / sar_mhz - 1;
  logic [7:0] hi_t [4] = '{8'h0F, 8'h1F, 8'h3F, 8'hFF};
  logic [7:0] lo_t [4] = '{8'hFF, 8'hFC, 8'hF8, 8'hF0};
  always #10 clk = ~clk;
  adcraf_top i_adcraf_top (.MCLK_I(clk), .SRST_I(rst), .SFR_ADDR_I(adr), .SFR_WDATA_I(wd),
    .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_RDATA_O(rdat), .EXT_START_I(ext), .SAMPLE_I(smp),
    .WINDOW_HIT_I(win), .GAIN_PATH_ON_O(gain), .CONVERSION_DONE_O(done));
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp_count++;
    if (rdat !== e) begin
      n_fail++;
      $display("unexpected reg %h: expected %h seen %h", a, e, rdat);
    end
  endtask
  task automatic bit_chk(input string n, input logic e, input logic s);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %b seen %b", n, e, s);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Polls settled values only, never in the launching edge's time step
  task automatic conv(input logic [7:0] c);
    int k;
    k = 0;
    wr_reg(8'hE8, c);
    idle(3);
    while (done !== 1'b1 && k < 1000) begin
      idle(1);
      k++;
    end
    bit_chk("done", 1'b1, done);
  endtask
  task automatic wrap_up;
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'hBC, 8'hF8);
    rd_chk(8'hBD, 8'h00);
    rd_chk(8'hBE, 8'h00);
    rd_chk(8'hE8, 8'h00);
    rd_chk(8'h55, 8'h00);
    wr_reg(8'hBD, 8'h5A);
    rd_chk(8'hBD, 8'h5A);
    wr_reg(8'hBC, 8'h01);
    idle(2);
    bit_chk("gain", 1'b1, gain);
    wr_reg(8'hBC, 8'h00);
    idle(2);
    bit_chk("gain", 1'b0, gain);
    $display("test registers over");
    conv(8'h90);
    rd_chk(8'hBE, 8'h0A);
    rd_chk(8'hBD, 8'hBC);
    conv(8'h94);
    rd_chk(8'hBE, 8'hAB);
    rd_chk(8'hBD, 8'hC0);
    $display("test justify over");
    @(posedge clk);
    smp <= 12'hFFF;
    win <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      wr_reg(8'hBC, {sar_div[4:0], r[1:0], 1'b0});
      conv(8'hC0 | 8'h10);
      rd_chk(8'hBE, hi_t[r]);
      rd_chk(8'hBD, lo_t[r]);
    end
    rd_chk(8'hE8, 8'hE8);
    $display("test burst repeats over");
    @(posedge clk);
    smp <= 12'h123;
    win <= 1'b0;
    wr_reg(8'hBC, 8'h02);
    for (int i = 0; i < 3; i++) begin
      wr_reg(8'hE8, 8'h90);
      idle(20);
      bit_chk("done", 1'b0, done);
    end
    conv(8'h90);
    rd_chk(8'hBE, 8'h04);
    rd_chk(8'hBD, 8'h8C);
    rd_chk(8'hE8, 8'hA0);
    $display("test single starts over");
    // Divider 1: 15 SAR clocks of 2 cycles, flag one cycle after the core ends
    wr_reg(8'hBC, 8'h08);
    wr_reg(8'hE8, 8'h90);
    idle(30);
    bit_chk("done", 1'b0, done);
    idle(1);
    bit_chk("done", 1'b1, done);
    $display("test divider timing over");
    wr_reg(8'hBC, 8'h00);
    wr_reg(8'hE8, 8'h91);
    idle(40);
    bit_chk("done", 1'b0, done);
    @(posedge clk);
    ext <= 1'b1;
    idle(40);
    bit_chk("done", 1'b1, done);
    @(posedge clk);
    ext <= 1'b0;
    rd_chk(8'hBE, 8'h01);
    rd_chk(8'hBD, 8'h23);
    $display("test start source over");
    wrap_up();
  end
endmodule
`default_nettype wire
